/* File: verilog/ota_consts.svh */
// Offsets, fields, reset values and codes of the over-temperature alert block.
`ifndef OTA_CONSTS_SVH
`define OTA_CONSTS_SVH
`define OTA_OFF_CONFIG 8'h00
`define OTA_OFF_LIMIT 8'h04
`define OTA_OFF_HYST 8'h08
`define OTA_OFF_TEMP 8'h0C
`define OTA_OFF_STATUS 8'h10
`define OTA_OFF_IRQ_STAT 8'h14
`define OTA_OFF_IRQ_MASK 8'h18
`define OTA_PTR_TEMP 2'h0
`define OTA_PTR_CONFIG 2'h1
`define OTA_PTR_HYST 2'h2
`define OTA_PTR_LIMIT 2'h3
`define OTA_CFG_SHDN 0
`define OTA_CFG_MODE 1
`define OTA_CFG_POL 2
`define OTA_CFG_FQ_LO 3
`define OTA_CFG_FQ_HI 4
`define OTA_CFG_FUNC 5
`define OTA_CFG_RESET 6'h00
`define OTA_LIMIT_RESET 16'h5000
`define OTA_HYST_RESET 16'h4B00
`define OTA_TEMP_RESET 16'h0000
`define OTA_FQ_CODE0 3'h1
`define OTA_FQ_CODE1 3'h2
`define OTA_FQ_CODE2 3'h4
`define OTA_FQ_CODE3 3'h6
`define OTA_IRQ_RISE 0
`define OTA_IRQ_FALL 1
`define OTA_IRQ_CONV 2
`define OTA_RESP_OKAY 2'h0
`define OTA_RESP_SLVERR 2'h2
`endif

/* File: verilog/ota_pkg.sv */
// Types shared by the over-temperature alert block.
package ota_pkg;
	typedef logic [1:0] ota_ptr_t;
	typedef enum logic [1:0] {RD_IDLE, RD_HIGH, RD_LOW} ota_rd_st_t;
	typedef enum logic {AL_IDLE, AL_ACTIVE} ota_al_st_t;
endpackage

/* File: verilog/ota_fault_queue.sv */
// Signed limit comparison and consecutive fault counter.
`timescale 1ns/100ps
`include "ota_consts.svh"
module ota_fault_queue #(
	parameter int TW = 12
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          conv_ok,
	input  wire logic [TW-1:0] temp,
	input  wire logic [TW-1:0] limit,
	input  wire logic [TW-1:0] hyst,
	input  wire logic [1:0]    queue_code,
	output logic               fault_hit,
	output logic               hyst_release,
	output logic [2:0]         fault_cnt,
	output logic [2:0]         fault_thr
);
	wire       over_limit = $signed(temp) >= $signed(limit);
	wire       below_hyst = $signed(temp) < $signed(hyst);
	wire [2:0] next_cnt   = !over_limit ? 3'h0 :
	                        (fault_cnt == `OTA_FQ_CODE3) ? fault_cnt : fault_cnt + 3'h1;
	assign fault_thr    = (queue_code == 2'h0) ? `OTA_FQ_CODE0 :
	                      (queue_code == 2'h1) ? `OTA_FQ_CODE1 :
	                      (queue_code == 2'h2) ? `OTA_FQ_CODE2 : `OTA_FQ_CODE3;
	assign fault_hit    = conv_ok && over_limit && (next_cnt >= fault_thr);
	assign hyst_release = conv_ok && below_hyst;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			fault_cnt <= 3'h0;
		else if (conv_ok)
			fault_cnt <= next_cnt;
	end
endmodule

/* File: verilog/ota_read_seq.sv */
// Byte sequencer for serial register read transfers.
`timescale 1ns/100ps
`include "ota_consts.svh"
module ota_read_seq
	import ota_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        xfer_start,
	input  wire logic        byte_req,
	input  wire logic        xfer_done,
	input  wire logic        single_byte,
	input  wire logic [15:0] sel_word,
	output logic      [7:0]  byte_data,
	output logic             byte_valid,
	output logic             rd_busy,
	output logic             rd_high,
	output logic             read_done
);
	ota_rd_st_t st;
	ota_rd_st_t next_st;

	assign rd_busy   = (st != RD_IDLE);
	assign rd_high   = (st == RD_HIGH);
	assign read_done = xfer_done && rd_busy;

	always_comb begin
		next_st = st;
		case (st)
			RD_IDLE: if (xfer_start) next_st = RD_HIGH;
			RD_HIGH: if (byte_req && !single_byte) next_st = RD_LOW;
			RD_LOW:  if (byte_req) next_st = RD_HIGH;
			default: next_st = RD_IDLE;
		endcase
		if (xfer_done)
			next_st = RD_IDLE;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st         <= RD_IDLE;
			byte_data  <= 8'h00;
			byte_valid <= 1'b0;
		end else begin
			st         <= next_st;
			byte_valid <= byte_req && rd_busy;
			if (byte_req && rd_busy)
				byte_data <= rd_high ? sel_word[15:8] : sel_word[7:0];
		end
	end
endmodule

/* File: verilog/ota_alert_top.sv */
// Over-temperature alert and register read logic with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "ota_consts.svh"
module ota_alert_top
	import ota_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,

	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,

	input  wire logic          conv_done,
	input  wire logic [15:0]   conv_temp,
	output logic               shutdown,

	input  wire logic          ptr_load,
	input  wire ota_pkg::ota_ptr_t ptr_index,
	input  wire logic          xfer_start,
	input  wire logic          byte_req,
	input  wire logic          xfer_done,
	output logic [7:0]         byte_data,
	output logic               byte_valid,

	output logic               overtemp_alert_output_o,
	output logic               overtemp_alert_output_oe,
	output logic               irq
);
	import ota_pkg::*;

	logic [5:0]  cfg;
	logic [15:0] limit;
	logic [15:0] hyst;
	logic [15:0] temp_q;
	ota_ptr_t    ptr_q;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	ota_al_st_t  al_st;
	logic        armed;

	logic          aw_hold;
	logic          w_hold;
	logic [AW-1:0] aw_addr_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;

	logic [2:0]  fault_cnt;
	logic [2:0]  fault_thr;
	logic        fault_hit;
	logic        hyst_release;
	logic        rd_busy;
	logic        rd_high;
	logic        read_done;

	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [31:0] d,
	                                        input logic [3:0]  s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Configuration fields.
	wire       cfg_shdn = cfg[`OTA_CFG_SHDN];
	wire       cfg_mode = cfg[`OTA_CFG_MODE];
	wire       cfg_pol  = cfg[`OTA_CFG_POL];
	wire       cfg_func = cfg[`OTA_CFG_FUNC];
	wire [1:0] cfg_fq   = cfg[`OTA_CFG_FQ_HI:`OTA_CFG_FQ_LO];

	// mode and function
	// The bus alert function shares the latched, read-cleared behaviour.
	wire int_mode     = cfg_mode || cfg_func;
	wire alert_active = (al_st == AL_ACTIVE);

	wire conv_ok = conv_done && !cfg_shdn;

	assign shutdown = cfg_shdn;

	// AXI4-Lite write channel: address and data may arrive in either order.
	assign awready = !aw_hold && !bvalid;
	assign wready  = !w_hold && !bvalid;

	wire          aw_take = awvalid && awready;
	wire          w_take  = wvalid && wready;
	wire          wr_fire = (aw_hold || aw_take) && (w_hold || w_take) && !bvalid;
	wire [AW-1:0] wr_addr = aw_hold ? aw_addr_q : awaddr;
	wire [31:0]   wr_data = w_hold ? w_data_q : wdata;
	wire [3:0]    wr_strb = w_hold ? w_strb_q : wstrb;

	wire wr_cfg   = wr_fire && (wr_addr == AW'(`OTA_OFF_CONFIG));
	wire wr_limit = wr_fire && (wr_addr == AW'(`OTA_OFF_LIMIT));
	wire wr_hyst  = wr_fire && (wr_addr == AW'(`OTA_OFF_HYST));
	wire wr_istat = wr_fire && (wr_addr == AW'(`OTA_OFF_IRQ_STAT));
	wire wr_imask = wr_fire && (wr_addr == AW'(`OTA_OFF_IRQ_MASK));
	wire wr_ro    = wr_fire && ((wr_addr == AW'(`OTA_OFF_TEMP)) ||
	                            (wr_addr == AW'(`OTA_OFF_STATUS)));
	wire wr_hit   = wr_cfg || wr_limit || wr_hyst || wr_istat || wr_imask || wr_ro;

	wire [15:0] next_limit = merge16(limit, wr_data, wr_strb);
	wire [15:0] next_hyst  = merge16(hyst, wr_data, wr_strb);
	wire [2:0]  istat_clr  = (wr_istat && wr_strb[0]) ? wr_data[2:0] : 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold   <= 1'b0;
			w_hold    <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `OTA_RESP_OKAY;
		end else begin
			if (aw_take)
				aw_addr_q <= awaddr;
			if (w_take) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			aw_hold <= !wr_fire && (aw_hold || aw_take);
			w_hold  <= !wr_fire && (w_hold || w_take);
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= wr_hit ? `OTA_RESP_OKAY : `OTA_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Software register file.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg      <= `OTA_CFG_RESET;
			limit    <= `OTA_LIMIT_RESET;
			hyst     <= `OTA_HYST_RESET;
			irq_mask <= 3'h0;
		end else begin
			if (wr_cfg && wr_strb[0])
				cfg <= wr_data[5:0];
			if (wr_limit)
				limit <= next_limit;
			if (wr_hyst)
				hyst <= next_hyst;
			if (wr_imask && wr_strb[0])
				irq_mask <= wr_data[2:0];
		end
	end

	// AXI4-Lite read channel.
	assign arready = !rvalid;

	wire ar_take = arvalid && arready;

	wire [31:0] status_word = {25'h0, fault_cnt, ptr_q, armed, alert_active};

	wire rd_cfg   = (araddr == AW'(`OTA_OFF_CONFIG));
	wire rd_limit = (araddr == AW'(`OTA_OFF_LIMIT));
	wire rd_hyst  = (araddr == AW'(`OTA_OFF_HYST));
	wire rd_temp  = (araddr == AW'(`OTA_OFF_TEMP));
	wire rd_stat  = (araddr == AW'(`OTA_OFF_STATUS));
	wire rd_istat = (araddr == AW'(`OTA_OFF_IRQ_STAT));
	wire rd_imask = (araddr == AW'(`OTA_OFF_IRQ_MASK));
	wire rd_hit   = rd_cfg || rd_limit || rd_hyst || rd_temp || rd_stat || rd_istat || rd_imask;

	wire [31:0] rd_word;
	assign rd_word = rd_cfg   ? {26'h0, cfg}      :
	                 rd_limit ? {16'h0, limit}    :
	                 rd_hyst  ? {16'h0, hyst}     :
	                 rd_temp  ? {16'h0, temp_q}   :
	                 rd_stat  ? status_word       :
	                 rd_istat ? {29'h0, irq_stat} :
	                 rd_imask ? {29'h0, irq_mask} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `OTA_RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= rd_hit ? `OTA_RESP_OKAY : `OTA_RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// Measurement and pointer capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_q <= `OTA_TEMP_RESET;
			ptr_q  <= `OTA_PTR_TEMP;
		end else begin
			if (conv_ok)
				temp_q <= conv_temp;
			if (ptr_load)
				ptr_q <= ptr_index;
		end
	end

	// Serial read path.
	wire ptr_is_cfg = (ptr_q == `OTA_PTR_CONFIG);

	// sixteen-bit words read as two bytes, the configuration as one
	wire [15:0] sel_word = ptr_is_cfg                   ? {2'h0, cfg, 8'h00} :
	                       (ptr_q == `OTA_PTR_HYST)     ? hyst  :
	                       (ptr_q == `OTA_PTR_LIMIT)    ? limit : temp_q;

	ota_read_seq u_read_seq (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.xfer_start  (xfer_start),
		.byte_req    (byte_req),
		.xfer_done   (xfer_done),
		.single_byte (ptr_is_cfg),
		.sel_word    (sel_word),
		.byte_data   (byte_data),
		.byte_valid  (byte_valid),
		.rd_busy     (rd_busy),
		.rd_high     (rd_high),
		.read_done   (read_done)
	);

	// The sensor delivers a 12-bit result; the low nibble never takes part in the compare.
	ota_fault_queue #(
		.TW (12)
	) u_fault_queue (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.conv_ok      (conv_ok),
		.temp         (conv_temp[15:4]),
		.limit        (limit[15:4]),
		.hyst         (hyst[15:4]),
		.queue_code   (cfg_fq),
		.fault_hit    (fault_hit),
		.hyst_release (hyst_release),
		.fault_cnt    (fault_cnt),
		.fault_thr    (fault_thr)
	);

	// Alert state machine.
	ota_al_st_t next_al_st;

	always_comb begin
		next_al_st = al_st;
		case (al_st)
			AL_IDLE: begin
				if (fault_hit && (!int_mode || armed))
					next_al_st = AL_ACTIVE;
			end
			AL_ACTIVE: begin
				if (!int_mode && hyst_release && !fault_hit)
					next_al_st = AL_IDLE;
				else if (int_mode && read_done && !(fault_hit && armed))
					next_al_st = AL_IDLE;
			end
			default: next_al_st = AL_IDLE;
		endcase
	end

	// re-arm only on a fresh conversion
	// A conversion that lands with the clearing read wins, so no result is lost.
	wire next_armed = conv_ok ? 1'b1 : (int_mode && read_done) ? 1'b0 : armed;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			al_st <= AL_IDLE;
			armed <= 1'b1;
		end else begin
			al_st <= next_al_st;
			armed <= next_armed;
		end
	end

	// open-drain pin polarity
	// Active high can only be shown by releasing the pin to its pull-up.
	assign overtemp_alert_output_o  = 1'b0;
	assign overtemp_alert_output_oe = cfg_pol ? !alert_active : alert_active;

	// Interrupt status: events set, a written one clears, a new event wins.
	wire       al_rise   = (next_al_st == AL_ACTIVE) && !alert_active;
	wire       al_fall   = (next_al_st == AL_IDLE) && alert_active;
	wire [2:0] irq_event = {conv_ok, al_fall, al_rise};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_stat <= 3'h0;
		else
			irq_stat <= (irq_stat & ~istat_clr) | irq_event;
	end

	assign irq = |(irq_stat & irq_mask);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_msb_req;
		byte_req && rd_busy && rd_high && !ptr_is_cfg;
	endsequence

	sequence s_lsb_req;
		byte_req && rd_busy && !rd_high;
	endsequence

	a_msb_first: assert property (
		s_msb_req |=> byte_valid && (byte_data == $past(sel_word[15:8])))
		else $error("high byte not returned first");

	a_lsb_second: assert property (
		s_lsb_req |=> byte_valid && (byte_data == $past(sel_word[7:0])))
		else $error("low byte not returned second");

	a_cfg_single: assert property (
		(byte_req && rd_high && ptr_is_cfg) ##1 1'b1 |-> byte_data == {2'h0, $past(cfg)})
		else $error("configuration byte wrong");

	a_reset_modes: assert property (
		$past(!aresetn) |-> (!cfg_mode && !cfg_func && !alert_active))
		else $error("reset mode not comparator over-temperature");

	a_cmp_set: assert property (
		(!int_mode && fault_hit) |=> alert_active)
		else $error("comparator alert did not assert");

	a_cmp_hold: assert property (
		(!int_mode && alert_active && !hyst_release && !read_done) |=> alert_active)
		else $error("comparator alert dropped early");

	a_cmp_release: assert property (
		(!int_mode && alert_active && hyst_release && !fault_hit) |=> !alert_active)
		else $error("comparator alert not released");

	a_shdn_hold: assert property (
		(cfg_shdn && !int_mode) |=> $stable(alert_active))
		else $error("shutdown changed comparator alert");

	a_int_clear: assert property (
		(int_mode && alert_active && read_done && !conv_ok) |=> !alert_active ##1 !alert_active)
		else $error("read did not clear interrupt alert");

	a_int_rearm: assert property (
		(int_mode && !armed && !alert_active) |=> !alert_active)
		else $error("interrupt alert returned before re-arm");

	a_queue_gate: assert property (
		$rose(alert_active) && !int_mode |-> fault_cnt >= fault_thr)
		else $error("alert raised before fault run complete");

	a_below_clears: assert property (
		(conv_ok && ($signed(conv_temp[15:4]) < $signed(limit[15:4]))) |=> fault_cnt == 3'h0)
		else $error("fault counter not cleared below limit");

	a_pin_level: assert property (
		$rose(alert_active) |-> (overtemp_alert_output_oe == !cfg_pol))
		else $error("alert pin level wrong for polarity");
endmodule

/* File: verification/ota_master_model.sv */
// Serial read master and alert line receiver facing the alert block.
`timescale 1ns/100ps
module ota_master_model
	import ota_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic [7:0]  byte_data,
	input  wire logic        byte_valid,
	input  wire logic        alert_oe,
	input  wire logic        alert_o,
	output ota_pkg::ota_ptr_t ptr_index,
	output logic             ptr_load,
	output logic             xfer_start,
	output logic             byte_req,
	output logic             xfer_done,
	output logic             alert_pin
);
	import ota_pkg::*;

	initial begin
		ptr_index = 2'h0;
		ptr_load = 1'h0;
		xfer_start = 1'h0;
		byte_req = 1'h0;
		xfer_done = 1'h0;
	end

	// Pulled-up line.
	// The line has a pull-up, so a released pin reads high, never a stale level.
	// A driven pin shows whatever level the block puts on it.
	assign alert_pin = alert_oe ? alert_o : 1'h1;

	task automatic serial_read(input ota_ptr_t p, input int n, output logic [15:0] w,
			output int lost);
		int i;
		int k;
		w = 16'h0000;
		lost = 0;
		@(posedge aclk);
		ptr_load <= 1'h1;
		ptr_index <= p;
		@(posedge aclk);
		ptr_load <= 1'h0;
		xfer_start <= 1'h1;
		@(posedge aclk);
		xfer_start <= 1'h0;
		for (i = 0; i < n; i++) begin
			byte_req <= 1'h1;
			@(posedge aclk);
			byte_req <= 1'h0;
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (byte_valid !== 1'h1 && k < 8);
			if (byte_valid !== 1'h1)
				lost++;
			w = {w[7:0], byte_data};
		end
		xfer_done <= 1'h1;
		@(posedge aclk);
		xfer_done <= 1'h0;
	endtask
endmodule

/* File: verification/tb.sv */
// Register, serial read and alert behaviour bench for the alert block.
`timescale 1ns/100ps
`include "ota_consts.svh"
module tb;
	import ota_pkg::*;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic        conv_done = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic [15:0] conv_temp = 16'h0000;
	logic        awready, wready, bvalid, arready, rvalid, shutdown, irq, oe, pin, pin_o;
	logic        ptr_load, xfer_start, byte_req, xfer_done, byte_valid;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [7:0]  byte_data;
	logic [15:0] w;
	ota_ptr_t    ptr_index;
	logic [2:0]  fq [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
	int          err_total = 0;
	int          n_compared = 0;
	int          lost, i, j;

	always #10 aclk = ~aclk;

	ota_alert_top #(.AW(8)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .conv_done(conv_done), .conv_temp(conv_temp), .shutdown(shutdown),
		.ptr_load(ptr_load), .ptr_index(ptr_index), .xfer_start(xfer_start),
		.byte_req(byte_req), .xfer_done(xfer_done), .byte_data(byte_data),
		.byte_valid(byte_valid), .overtemp_alert_output_o(pin_o), .overtemp_alert_output_oe(oe),
		.irq(irq));

	ota_master_model mst_u (.aclk(aclk), .byte_data(byte_data), .byte_valid(byte_valid),
		.alert_oe(oe), .alert_o(pin_o), .ptr_index(ptr_index), .ptr_load(ptr_load),
		.xfer_start(xfer_start), .byte_req(byte_req), .xfer_done(xfer_done), .alert_pin(pin));

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", name, e, g);
			err_total++;
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// Only the watchdog ends a wait that never sees an answer.
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk("write_resp", {30'h0, `OTA_RESP_OKAY}, {30'h0, bresp});
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			k++;
			if (arvalid && arready)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		// The slave answers on the edge that takes the address; the bench sees it one edge later.
		chk("read_latency", 32'h2, k);
	endtask

	// A conversion result, then one edge for the pin enable to follow.
	task automatic conv(input logic [15:0] t);
		@(posedge aclk);
		conv_done <= 1'h1;
		conv_temp <= t;
		@(posedge aclk);
		conv_done <= 1'h0;
		@(posedge aclk);
		#1;
	endtask

	task automatic sread(input ota_ptr_t p, input int n);
		mst_u.serial_read(p, n, w, lost);
		chk("bytes_lost", 32'h0, lost);
		@(posedge aclk);
		#1;
	endtask

	// Active-low polarity drives the pin low when active; active-high releases it.
	task automatic alert_is(input logic act, input logic pl);
		chk("alert_pin", {31'h0, act ~^ pl}, {31'h0, pin});
	endtask

	task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, rd, rsp);
		chk("reg_value", e, rd);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		#1;
		chk("oe_reset", 32'h0, {31'h0, oe});
		chk("shutdown_reset", 32'h0, {31'h0, shutdown});
		reg_is(`OTA_OFF_CONFIG, 32'h0);
		reg_is(`OTA_OFF_LIMIT, 32'h5000);
		reg_is(`OTA_OFF_HYST, 32'h4B00);
		axi_rd(8'h1C, rd, rsp);
		chk("unmapped_resp", {30'h0, `OTA_RESP_SLVERR}, {30'h0, rsp});
		conv(16'h1230);
		reg_is(`OTA_OFF_TEMP, 32'h1230);
		sread(`OTA_PTR_TEMP, 2);
		chk("temp_bytes", 32'h1230, {16'h0, w});
		sread(`OTA_PTR_CONFIG, 1);
		chk("config_byte", 32'h0, {24'h0, w[7:0]});
		sread(`OTA_PTR_LIMIT, 2);
		chk("limit_bytes", 32'h5000, {16'h0, w});
		sread(`OTA_PTR_HYST, 2);
		chk("hyst_bytes", 32'h4B00, {16'h0, w});
		conv(16'h5000);
		alert_is(1'h1, 1'h0);
		conv(16'h4B00);
		alert_is(1'h1, 1'h0);
		axi_wr(`OTA_OFF_CONFIG, 32'h1);
		chk("shutdown_on", 32'h1, {31'h0, shutdown});
		conv(16'h0000);
		alert_is(1'h1, 1'h0);
		axi_wr(`OTA_OFF_CONFIG, 32'h0);
		conv(16'h4AF0);
		alert_is(1'h0, 1'h0);
		axi_wr(`OTA_OFF_LIMIT, 32'hFF00);
		axi_wr(`OTA_OFF_HYST, 32'hFE00);
		conv(16'h0100);
		alert_is(1'h1, 1'h0);
		conv(16'hFDF0);
		alert_is(1'h0, 1'h0);
		axi_wr(`OTA_OFF_LIMIT, 32'h5000);
		axi_wr(`OTA_OFF_HYST, 32'h4B00);
		axi_wr(`OTA_OFF_CONFIG, 32'h4);
		alert_is(1'h0, 1'h1);
		conv(16'h5000);
		alert_is(1'h1, 1'h1);
		conv(16'h1000);
		alert_is(1'h0, 1'h1);
		for (i = 0; i < 4; i++) begin
			axi_wr(`OTA_OFF_CONFIG, {27'h0, i[1:0], 3'h2});
			sread(`OTA_PTR_CONFIG, 1);
			chk("config_mode", {27'h0, i[1:0], 3'h2}, {24'h0, w[7:0]});
			conv(16'h1000);
			for (j = 1; j < fq[i]; j++)
				conv(16'h6000);
			if (fq[i] > 3'h1) begin
				conv(16'h1000);
				for (j = 1; j < fq[i]; j++)
					conv(16'h6000);
			end
			alert_is(1'h0, 1'h0);
			conv(16'h6000);
			alert_is(1'h1, 1'h0);
			sread(`OTA_PTR_TEMP, 2);
			alert_is(1'h0, 1'h0);
		end
		axi_wr(`OTA_OFF_CONFIG, 32'h2);
		conv(16'h6000);
		alert_is(1'h0, 1'h0);
		conv(16'h6000);
		alert_is(1'h1, 1'h0);
		chk("irq_masked", 32'h0, {31'h0, irq});
		axi_rd(`OTA_OFF_IRQ_STAT, rd, rsp);
		chk("irq_status", 32'h1, {31'h0, rd[`OTA_IRQ_RISE]});
		axi_wr(`OTA_OFF_IRQ_MASK, 32'h1);
		chk("irq_raised", 32'h1, {31'h0, irq});
		axi_wr(`OTA_OFF_IRQ_STAT, 32'h1);
		chk("irq_cleared", 32'h0, {31'h0, irq});
		axi_wr(`OTA_OFF_CONFIG, 32'h20);
		alert_is(1'h1, 1'h0);
		sread(`OTA_PTR_TEMP, 2);
		alert_is(1'h0, 1'h0);
		conv(16'h6000);
		alert_is(1'h0, 1'h0);
		conv(16'h6000);
		alert_is(1'h1, 1'h0);
		end_of_test();
	end
endmodule
